// *** hw/cad_pkg.sv ***
// package for the cpu arithmetic datapath: register map, fields, codes, state
// assumes a 32-bit ahb-lite register bus and a single 40 MHz core clock
package cad_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_OPA     = 8'h08;
  localparam logic [7:0] OFS_OPB     = 8'h0C;
  localparam logic [7:0] OFS_CMD     = 8'h10;
  localparam logic [7:0] OFS_RESULT  = 8'h14;
  localparam logic [7:0] OFS_RES_HI  = 8'h18;
  localparam logic [7:0] OFS_QUOT    = 8'h1C;
  localparam logic [7:0] OFS_REM     = 8'h20;
  localparam logic [7:0] OFS_DIV_HI  = 8'h24;
  localparam logic [7:0] OFS_MISC    = 8'h28;
  localparam logic [7:0] OFS_PADDR   = 8'h2C;

  // status field positions
  localparam int SR_C   = 0;
  localparam int SR_Z   = 1;
  localparam int SR_OV  = 2;
  localparam int SR_N   = 3;
  localparam int SR_RA  = 4;
  localparam int SR_IPL = 5;
  localparam int SR_DC  = 8;
  // control field positions
  localparam int CC_PSV  = 2;
  localparam int CC_PRIORITY_HIGH_BIT = 3;
  // misc field positions
  localparam int MI_NEST  = 0;
  localparam int MI_HOLD  = 1;
  localparam int MI_TBLOP = 2;
  localparam int MI_PAGE  = 8;
  localparam int PA_OK    = 24;
  // command field positions
  localparam int CM_BYTE = 4;
  localparam int CM_MODE = 5;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_IPL  = 3'h0;

  // divider timing: prep cycle, one per divisor bit, fixup and writeback
  localparam int          DIV_BITS   = 16;
  localparam logic [4:0]  DIV_CYCLES = 5'h13;
  localparam logic [4:0]  DIV_LAST_I = 5'h11;

  // operation codes
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3, OP_XOR = 4'h4,
    OP_ASR = 4'h5, OP_LSR = 4'h6, OP_SL  = 4'h7, OP_MUL = 4'h8, OP_DIV = 4'h9
  } cad_op_e;

  // multiplier modes
  localparam logic [2:0] MM_SS = 3'h0;
  localparam logic [2:0] MM_UU = 3'h1;
  localparam logic [2:0] MM_SU = 3'h2;
  localparam logic [2:0] MM_US = 3'h3;
  localparam logic [2:0] MM_SL = 3'h4;
  localparam logic [2:0] MM_UL = 3'h5;
  localparam logic [2:0] MM_U8 = 3'h6;

  typedef enum logic [3:0] {
    DV_IDLE = 4'b0001, DV_PREP = 4'b0010, DV_ITER = 4'b0100, DV_DONE = 4'b1000
  } cad_div_e;

  // status flag group
  typedef struct packed {
    logic       dc;
    logic [2:0] ipl;
    logic       ra;
    logic       n;
    logic       ov;
    logic       z;
    logic       c;
  } cad_flags_s;

  // whole module state
  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
    logic        rd_pend;
    logic [7:0]  rd_addr;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    cad_flags_s  sr;
    logic        priority_high_bit;
    logic        program_window_enable;
    logic [3:0]  prio;
    logic        usr_dis;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] div_hi;
    logic [15:0] result;
    logic [15:0] res_hi;
    logic [15:0] quot;
    logic [15:0] rem;
    logic        nest_dis;
    logic        div_hold;
    logic        tbl_op;
    logic [7:0]  page;
    logic [23:0] paddr;
    logic        addr_ok;
    logic        loop_m;
    logic        loop_s;
    logic        ph_m;
    logic        ph_s;
    cad_div_e    dv_st;
    logic [4:0]  dv_cnt;
    logic [16:0] dv_rem;
    logic [15:0] dv_dvd;
    logic [15:0] dv_dsr;
    logic        dv_neg_q;
    logic        dv_neg_r;
  } cad_state_s;

endpackage

// *** hw/cad_datapath.sv ***
// cpu arithmetic datapath: alu, flags, multiplier, divider, shifter, control
// assumes one ahb-lite master, a synchronous active-low reset and 40 MHz clock
//
// Summary of operation
// - half-carry flag takes carry out of bit 3 (byte) or bit 7 (word)
// - status bits 7..5 hold binary cpu priority level 0 to 7
// - nesting disable makes the priority status bits read-only
// - priority high bit joins the three status bits into a four-bit level
// - loop busy flag follows the hardware repeat loop; read-only
// - negative flag set for negative results, cleared for zero or positive
// - signed wrap flag set on two's-complement overflow, else cleared
// - zero flag set by zero results, cleared by nonzero results
// - carry flag set on carry out of the result's top bit
// - subtract carry and half-carry are inverted borrows
// - priority high bit: hardware only sets, software only clears, resets 0
// - program window enable is read/write and resets 0
// - unimplemented status and control bits always read zero
// - 16-bit alu: add, subtract, shifts, logic; two's complement
// - alu add, subtract and logic work in byte or word size, shifts in word size only; operands and results in registers
// - 17x17 multiplier: signed, unsigned, mixed, literal and 8x8 modes
// - divider handles signed and unsigned 32/16 and 16/16 division
// - quotient to the quotient register, remainder to the remainder register
// - divider iterates one cycle per divisor bit for both dividend sizes
// - every divide takes 19 cycles and may pause at any cycle boundary
// - shifter does arithmetic right, logical right or left shift up to 15
// - multi-bit shifts use registers only, never memory
// - program addresses are 24 bits; user access limited to lower half
// - table access reaches configuration space only with table page bit 7 set
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cad_datapath (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // core status from outside logic
  input  wire logic        LOOP_ACTIVE,
  input  wire logic        PRIO_HIGH_SET,
  // core status outputs
  output logic      [3:0]  PRIORITY_LEVEL,
  output logic             USER_IRQ_DISABLE,
  output logic             PROG_WINDOW_EN,
  output logic             DIV_BUSY,
  output logic             PROG_ADDR_OK
);

  // add or subtract with carry, digit carry and overflow; returns {c,dc,ov,res}
  function automatic logic [18:0] add_sub(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub, input logic byte_op);
    logic [15:0] bb;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [4:0]  s4;
    logic        cin;
    logic        c;
    logic        dc;
    logic        ov;
    logic [15:0] res;
    bb  = sub ? ~b : b;
    cin = sub;
    s16 = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
    s8  = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
    s4  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    if (byte_op) begin
      res = {a[15:8], s8[7:0]};
      c   = s8[8];
      dc  = s4[4];
      ov  = (a[7] == bb[7]) && (s8[7] != a[7]);
    end else begin
      res = s16[15:0];
      c   = s16[16];
      dc  = s8[8];
      ov  = (a[15] == bb[15]) && (s16[15] != a[15]);
    end
    return {c, dc, ov, res};
  endfunction

  // two's-complement magnitude of a 32-bit value
  function automatic logic [31:0] mag32(input logic [31:0] v, input logic neg);
    return neg ? 32'(~v + 32'h0000_0001) : v;
  endfunction

  cad_pkg::cad_state_s st_q;
  cad_pkg::cad_state_s st_d;

  // combinational helpers
  logic [7:0]  acc_addr;
  logic        acc_ok;
  logic [15:0] wd;
  logic        cmd_go;
  logic [3:0]  cmd_op;
  logic        cmd_byte;
  logic [2:0]  cmd_mode;
  logic [18:0] as_out;
  logic [15:0] lres;
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] prod;
  logic [31:0] dv_full;
  logic        dv_sgn;
  logic        dv_dsgn;
  logic [31:0] dv_mag;
  logic [16:0] dv_try;
  logic [31:0] rd_mux;
  logic        bytew;

  // bus address phase qualifier
  assign acc_ok   = HSEL && HREADY && HTRANS[1];
  assign acc_addr = (HADDR[31:8] == 24'h000000) ? HADDR[7:0] : 8'hFF;
  assign wd       = HWDATA[15:0];
  assign cmd_go   = st_q.wr_pend && (st_q.wr_addr == cad_pkg::OFS_CMD);
  assign cmd_op   = wd[3:0];
  assign cmd_byte = wd[cad_pkg::CM_BYTE];
  assign cmd_mode = wd[cad_pkg::CM_MODE +: 3];

  // shared adder for add and subtract
  assign as_out = add_sub(st_q.opa, st_q.opb, cmd_op == cad_pkg::OP_SUB, cmd_byte);

  // multiplier operand extension into the 17x17 array
  always_comb begin
    unique case (cmd_mode)
      cad_pkg::MM_SS: begin
        ma = {st_q.opa[15], st_q.opa};
        mb = {st_q.opb[15], st_q.opb};
      end
      cad_pkg::MM_UU: begin
        ma = {1'b0, st_q.opa};
        mb = {1'b0, st_q.opb};
      end
      cad_pkg::MM_SU: begin
        ma = {st_q.opa[15], st_q.opa};
        mb = {1'b0, st_q.opb};
      end
      cad_pkg::MM_US: begin
        ma = {1'b0, st_q.opa};
        mb = {st_q.opb[15], st_q.opb};
      end
      cad_pkg::MM_SL: begin
        ma = {st_q.opa[15], st_q.opa};
        mb = {12'h000, st_q.opb[4:0]};
      end
      cad_pkg::MM_UL: begin
        ma = {1'b0, st_q.opa};
        mb = {12'h000, st_q.opb[4:0]};
      end
      cad_pkg::MM_U8: begin
        ma = {9'h000, st_q.opa[7:0]};
        mb = {9'h000, st_q.opb[7:0]};
      end
      default: begin
        ma = {1'b0, st_q.opa};
        mb = {1'b0, st_q.opb};
      end
    endcase
  end
  assign prod = 34'($signed(ma) * $signed(mb));

  // divider operand preparation
  assign bytew   = st_q.opa[15];
  assign dv_full = cmd_mode[1] ? {st_q.div_hi, st_q.opa}
                 : (cmd_mode[0] ? {{16{bytew}}, st_q.opa} : {16'h0000, st_q.opa});
  assign dv_sgn  = cmd_mode[0] && dv_full[31];
  assign dv_dsgn = cmd_mode[0] && st_q.opb[15];
  assign dv_mag  = mag32(dv_full, dv_sgn);
  assign dv_try  = {st_q.dv_rem[15:0], st_q.dv_dvd[15]};

  // register read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (st_q.rd_addr)
      cad_pkg::OFS_STATUS:  rd_mux = {23'h000000, st_q.sr};
      cad_pkg::OFS_CONTROL: rd_mux = {28'h0000000, st_q.priority_high_bit, st_q.program_window_enable, 2'b00};
      cad_pkg::OFS_OPA:     rd_mux = {16'h0000, st_q.opa};
      cad_pkg::OFS_OPB:     rd_mux = {16'h0000, st_q.opb};
      cad_pkg::OFS_RESULT:  rd_mux = {16'h0000, st_q.result};
      cad_pkg::OFS_RES_HI:  rd_mux = {16'h0000, st_q.res_hi};
      cad_pkg::OFS_QUOT:    rd_mux = {16'h0000, st_q.quot};
      cad_pkg::OFS_REM:     rd_mux = {16'h0000, st_q.rem};
      cad_pkg::OFS_DIV_HI:  rd_mux = {16'h0000, st_q.div_hi};
      cad_pkg::OFS_MISC:    rd_mux = {16'h0000, st_q.page, 4'h0, st_q.dv_st != cad_pkg::DV_IDLE,
                                      st_q.tbl_op, st_q.div_hold, st_q.nest_dis};
      cad_pkg::OFS_PADDR:   rd_mux = {7'h00, st_q.addr_ok, st_q.paddr};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    lres = st_q.opa;

    // input synchronisers
    st_d.loop_m = LOOP_ACTIVE;
    st_d.loop_s = st_q.loop_m;
    st_d.ph_m   = PRIO_HIGH_SET;
    st_d.ph_s   = st_q.ph_m;

    // bus: reads take one wait state so data come from settled registers
    st_d.wr_pend = acc_ok && HWRITE;
    st_d.rd_pend = acc_ok && !HWRITE;
    if (acc_ok) begin
      st_d.wr_addr = acc_addr;
      st_d.rd_addr = acc_addr;
    end
    st_d.ready = !(acc_ok && !HWRITE);
    if (st_q.rd_pend) begin
      st_d.rdata = rd_mux;
      st_d.ready = 1'b1;
    end

    // software register writes
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        cad_pkg::OFS_STATUS: begin
          st_d.sr.dc = wd[cad_pkg::SR_DC];
          st_d.sr.n  = wd[cad_pkg::SR_N];
          st_d.sr.ov = wd[cad_pkg::SR_OV];
          st_d.sr.z  = wd[cad_pkg::SR_Z];
          st_d.sr.c  = wd[cad_pkg::SR_C];
          if (!st_q.nest_dis) begin
            st_d.sr.ipl = wd[cad_pkg::SR_IPL +: 3];
          end
        end
        cad_pkg::OFS_CONTROL: begin
          st_d.program_window_enable = wd[cad_pkg::CC_PSV];
          if (!wd[cad_pkg::CC_PRIORITY_HIGH_BIT]) begin
            st_d.priority_high_bit = 1'b0;
          end
        end
        cad_pkg::OFS_OPA:    st_d.opa    = wd;
        cad_pkg::OFS_OPB:    st_d.opb    = wd;
        cad_pkg::OFS_DIV_HI: st_d.div_hi = wd;
        cad_pkg::OFS_MISC: begin
          st_d.nest_dis = wd[cad_pkg::MI_NEST];
          st_d.div_hold = wd[cad_pkg::MI_HOLD];
          st_d.tbl_op   = wd[cad_pkg::MI_TBLOP];
          st_d.page     = wd[cad_pkg::MI_PAGE +: 8];
        end
        cad_pkg::OFS_PADDR:  st_d.paddr  = HWDATA[23:0];
        default: begin
        end
      endcase
    end

    // command execution: result and flags commit on the same edge
    if (cmd_go) begin
      unique case (cmd_op)
        cad_pkg::OP_ADD, cad_pkg::OP_SUB: begin
          lres       = as_out[15:0];
          st_d.sr.c  = as_out[18];
          st_d.sr.dc = as_out[17];
          st_d.sr.ov = as_out[16];
        end
        cad_pkg::OP_AND: lres = st_q.opa & st_q.opb;
        cad_pkg::OP_IOR: lres = st_q.opa | st_q.opb;
        cad_pkg::OP_XOR: lres = st_q.opa ^ st_q.opb;
        // register-held operand in, register result out
        cad_pkg::OP_ASR: lres = 16'($signed(st_q.opa) >>> st_q.opb[3:0]);
        cad_pkg::OP_LSR: lres = st_q.opa >> st_q.opb[3:0];
        cad_pkg::OP_SL:  lres = 16'(st_q.opa << st_q.opb[3:0]);
        default:         lres = st_q.opa;
      endcase
      if (cmd_op <= cad_pkg::OP_XOR && cmd_byte) begin
        lres = {st_q.opa[15:8], lres[7:0]};
      end
      if (cmd_op == cad_pkg::OP_MUL) begin
        st_d.result = prod[15:0];
        st_d.res_hi = prod[31:16];
      end else if (cmd_op == cad_pkg::OP_DIV) begin
        if (st_q.dv_st == cad_pkg::DV_IDLE) begin
          st_d.dv_st    = cad_pkg::DV_PREP;
          st_d.dv_cnt   = 5'h01;
          st_d.dv_rem   = {1'b0, dv_mag[31:16]};
          st_d.dv_dvd   = dv_mag[15:0];
          st_d.dv_dsr   = dv_dsgn ? 16'(~st_q.opb + 16'h0001) : st_q.opb;
          st_d.dv_neg_q = dv_sgn ^ dv_dsgn;
          st_d.dv_neg_r = dv_sgn;
        end
      end else begin
        st_d.result = lres;
        st_d.sr.n   = cmd_byte && cmd_op <= cad_pkg::OP_XOR ? lres[7] : lres[15];
        if (cmd_byte && cmd_op <= cad_pkg::OP_XOR) begin
          st_d.sr.z = (lres[7:0] == 8'h00);
        end else begin
          st_d.sr.z = (lres == 16'h0000);
        end
      end
    end

    // divider, paused while the hold bit is set
    if (!st_q.div_hold) begin
      unique case (st_q.dv_st)
        cad_pkg::DV_IDLE: begin
        end
        cad_pkg::DV_PREP: begin
          st_d.dv_st  = cad_pkg::DV_ITER;
          st_d.dv_cnt = 5'(st_q.dv_cnt + 5'h01);
        end
        cad_pkg::DV_ITER: begin
          // one restoring step per divisor bit
          if (dv_try >= {1'b0, st_q.dv_dsr}) begin
            st_d.dv_rem = 17'(dv_try - {1'b0, st_q.dv_dsr});
            st_d.dv_dvd = {st_q.dv_dvd[14:0], 1'b1};
          end else begin
            st_d.dv_rem = dv_try;
            st_d.dv_dvd = {st_q.dv_dvd[14:0], 1'b0};
          end
          st_d.dv_cnt = 5'(st_q.dv_cnt + 5'h01);
          if (st_q.dv_cnt == cad_pkg::DIV_LAST_I) begin
            st_d.dv_st = cad_pkg::DV_DONE;
          end
        end
        cad_pkg::DV_DONE: begin
          st_d.dv_cnt = 5'(st_q.dv_cnt + 5'h01);
          if (st_q.dv_cnt == 5'(cad_pkg::DIV_CYCLES - 5'h01)) begin
            // sign fixup in the first done cycle
            st_d.dv_dvd = st_q.dv_neg_q ? 16'(~st_q.dv_dvd + 16'h0001) : st_q.dv_dvd;
            st_d.dv_rem = st_q.dv_neg_r ? 17'(~st_q.dv_rem + 17'h00001) : st_q.dv_rem;
          end else begin
            st_d.quot  = st_q.dv_dvd;
            st_d.rem   = st_q.dv_rem[15:0];
            st_d.dv_st = cad_pkg::DV_IDLE;
          end
        end
        default: st_d.dv_st = cad_pkg::DV_IDLE;
      endcase
    end

    // hardware-owned status
    st_d.sr.ra = st_q.loop_s;
    if (st_q.ph_s) begin
      st_d.priority_high_bit = 1'b1;
    end

    // derived outputs
    st_d.prio    = {st_d.priority_high_bit, st_d.sr.ipl};
    st_d.usr_dis = st_d.priority_high_bit || (st_d.sr.ipl == 3'h7);
    st_d.addr_ok = !st_d.paddr[23] || (st_d.tbl_op && st_d.page[7]);
  end

  // state register with synchronous reset
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_q          <= '0;
      st_q.ready    <= 1'b1;
      st_q.sr.ipl   <= cad_pkg::RST_IPL;
      st_q.opa      <= cad_pkg::RST_WORD;
      st_q.dv_st    <= cad_pkg::DV_IDLE;
      st_q.addr_ok  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register, HRESP tied low
  assign HRDATA           = st_q.rdata;
  assign HREADYOUT        = st_q.ready;
  assign HRESP            = 1'b0;
  assign PRIORITY_LEVEL   = st_q.prio;
  assign USER_IRQ_DISABLE = st_q.usr_dis;
  assign PROG_WINDOW_EN   = st_q.program_window_enable;
  assign DIV_BUSY         = st_q.dv_st != cad_pkg::DV_IDLE;
  assign PROG_ADDR_OK     = st_q.addr_ok;

endmodule

`default_nettype wire

// *** testbench/cad_datapath_monitor.sv ***
// checker for the cpu arithmetic datapath: bus timing, priority, divider
// bound into cad_datapath; sees its ports only
`timescale 1ns/10ps
`default_nettype none

module cad_datapath_monitor (
  // clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // ahb-lite slave side
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // core status
  input wire logic        PRIO_HIGH_SET,
  input wire logic [3:0]  PRIORITY_LEVEL,
  input wire logic        USER_IRQ_DISABLE,
  input wire logic        PROG_WINDOW_EN,
  input wire logic        DIV_BUSY,
  input wire logic        PROG_ADDR_OK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic       rd_take;
  logic       wr_take;
  logic [5:0] busy_q;

  // address phases taken by the slave
  assign rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign wr_take = HSEL && HREADY && HTRANS[1] && HWRITE;

  // busy cycles of the current divide, saturating
  always_ff @(posedge CLK) begin
    if (!NRST || !DIV_BUSY) begin
      busy_q <= 6'h00;
    end else begin
      busy_q <= (busy_q == 6'h3F) ? busy_q : busy_q + 6'h01;
    end
  end

  a_bus_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_take |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_take |=> HREADYOUT)
    else $error("write stalled");
  a_ready_cause: assert property ($fell(HREADYOUT) |-> $past(rd_take))
    else $error("wait state without read");
  a_reset_clear: assert property ($rose(NRST) |-> PRIORITY_LEVEL == 4'h0 && !PROG_WINDOW_EN
    && !DIV_BUSY && PROG_ADDR_OK && HREADYOUT) else $error("reset values wrong");
  a_irq_split: assert property (USER_IRQ_DISABLE == (PRIORITY_LEVEL[3] || PRIORITY_LEVEL[2:0] == 3'h7))
    else $error("user interrupt disable wrong");
  a_div_span: assert property ($fell(DIV_BUSY) |-> busy_q >= 6'h13)
    else $error("divide too short");
  a_prio_hw: assert property (PRIO_HIGH_SET [*3] |-> ##[1:2] PRIORITY_LEVEL[3])
    else $error("hardware priority raise missed");
  a_priority_high_bit_cause: assert property ($rose(PRIORITY_LEVEL[3]) |->
    $past(PRIO_HIGH_SET, 2) || $past(PRIO_HIGH_SET, 3) || $past(PRIO_HIGH_SET, 4))
    else $error("priority high bit set by software");
endmodule

bind cad_datapath cad_datapath_monitor mon (
  .CLK, .NRST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .PRIO_HIGH_SET, .PRIORITY_LEVEL,
  .USER_IRQ_DISABLE, .PROG_WINDOW_EN, .DIV_BUSY, .PROG_ADDR_OK
);
`default_nettype wire

// *** testbench/cad_core_model.sv ***
// core-side model: repeat loop and priority raise levels
// assumes bench requests on rising edges
`timescale 1ns/10ps
`default_nettype none

module cad_core_model (
  // clock
  input  wire logic CLK,
  // bench requests
  input  wire logic loop_req,
  input  wire logic prio_req,
  // status toward the datapath
  output logic      loop_active,
  output logic      prio_high_set
);
  // levels launched off the core clock
  always_ff @(posedge CLK) begin
    loop_active   <= loop_req;
    prio_high_set <= prio_req;
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the cpu arithmetic datapath over ahb-lite
// assumes package, datapath, core model and checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb;
  logic        CLK, NRST, HWRITE, HREADYOUT, HRESP, LOOP_ACTIVE, PRIO_HIGH_SET, loop_req, prio_req;
  logic        USER_IRQ_DISABLE, PROG_WINDOW_EN, DIV_BUSY, PROG_ADDR_OK;
  logic [1:0]  HTRANS;
  logic [3:0]  PRIORITY_LEVEL;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  int          num_errors = 0, checks_done = 0;

  cad_datapath dut (
    .CLK, .NRST, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA,
    .HREADYOUT, .HRESP, .LOOP_ACTIVE, .PRIO_HIGH_SET, .PRIORITY_LEVEL, .USER_IRQ_DISABLE, .PROG_WINDOW_EN,
    .DIV_BUSY, .PROG_ADDR_OK
  );
  cad_core_model core (
    .CLK(CLK), .loop_req(loop_req), .prio_req(prio_req), .loop_active(LOOP_ACTIVE),
    .prio_high_set(PRIO_HIGH_SET)
  );

  // 40 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // one single transfer: address phase, then data phase, each until ready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    HADDR  <= a;
    HWRITE <= w;
    HTRANS <= 2'b10;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1 && t < 50) begin
      @(posedge CLK);
      t++;
    end
    HTRANS <= 2'b00;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1 && t < 50) begin
      @(posedge CLK);
      t++;
    end
    if (t >= 50) num_errors++;
    q = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus({24'h0, a}, 1'b1, d, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus({24'h0, a}, 1'b0, 32'h0, rd);
    `CHK($sformatf("register %h", a), e, rd)
  endtask

  // reference alu: {half carry, negative, wrap, zero, carry, result}
  function automatic logic [20:0] alu_ref(input logic [3:0] op, input logic by, input logic [15:0] a, b);
    logic [16:0] s;
    logic [15:0] bb, r, cy;
    logic        wb;
    wb = by && op < 4'h5;
    bb = (op == 4'h1) ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + {16'h0, op == 4'h1};
    cy = s[15:0] ^ a ^ bb;
    case (op)
      4'h0, 4'h1: r = s[15:0];
      4'h2: r = a & b;
      4'h3: r = a | b;
      4'h4: r = a ^ b;
      4'h5: r = $signed(a) >>> b[3:0];
      4'h6: r = a >> b[3:0];
      default: r = a << b[3:0];
    endcase
    if (wb) r[15:8] = a[15:8];
    return {wb ? cy[4] : cy[8], wb ? r[7] : r[15], wb ? cy[7] ^ cy[8] : cy[15] ^ s[16],
            wb ? r[7:0] == 8'h0 : r == 16'h0, wb ? cy[8] : s[16], r};
  endfunction

  // reset values and an unmapped place
  task automatic t_reset;
    rdc(cad_pkg::OFS_STATUS, 32'h0);
    rdc(cad_pkg::OFS_CONTROL, 32'h0);
    rdc(cad_pkg::OFS_PADDR, 32'h0100_0000);
    bus(32'h0000_0100, 1'b0, 32'h0, rd);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("level after reset", 4'h0, PRIORITY_LEVEL)
    $display("reset done");
  endtask

  // every alu op on edge operands in word size, and add, subtract and logic ops in byte size
  task automatic t_alu;
    logic [31:0] pr [4];
    logic [20:0] e;
    pr = '{32'h7FFF_0001, 32'h8000_8000, 32'h0005_0005, 32'h00F8_0009};
    for (int i = 0; i < 4; i++) begin
      for (int op = 0; op < 8; op++) begin
        for (int by = 0; by < 2; by++) begin
          if (by == 0 || op < 5) begin
            e = alu_ref(op[3:0], by[0], pr[i][31:16], pr[i][15:0]);
            wr(cad_pkg::OFS_OPA, {16'h0, pr[i][31:16]});
            wr(cad_pkg::OFS_OPB, {16'h0, pr[i][15:0]});
            wr(cad_pkg::OFS_CMD, {27'h0, by[0], op[3:0]});
            rdc(cad_pkg::OFS_RESULT, {16'h0, e[15:0]});
            bus({24'h0, cad_pkg::OFS_STATUS}, 1'b0, 32'h0, rd);
            if (op < 2) begin
              `CHK("arith flags", {23'h0, e[20], 4'h0, e[19:16]}, rd)
            end else begin
              `CHK("logic flags", {e[19], e[17]}, {rd[3], rd[1]})
            end
          end
        end
      end
    end
    $display("alu done");
  endtask

  // all multiplier modes on mixed-sign operands
  task automatic t_mul;
    longint pa [7], pb [7], p;
    pa = '{-2, 'hFFFE, -2, 'hFFFE, -2, 'hFFFE, 'hFE};
    pb = '{-32539, 'h80E5, 'h80E5, -32539, 5, 5, 'hE5};
    wr(cad_pkg::OFS_OPA, 32'h0000_FFFE);
    wr(cad_pkg::OFS_OPB, 32'h0000_80E5);
    for (int m = 0; m < 7; m++) begin
      wr(cad_pkg::OFS_CMD, {24'h0, m[2:0], 5'h08});
      p = pa[m] * pb[m];
      rdc(cad_pkg::OFS_RESULT, {16'h0, p[15:0]});
      rdc(cad_pkg::OFS_RES_HI, {16'h0, p[31:16]});
    end
    $display("multiply done");
  endtask

  // signed and unsigned divides in both dividend sizes
  task automatic t_div;
    logic [49:0] tc [4];
    int          n, dd, dv;
    tc = '{{2'b10, 48'h0000_FF9C_0007}, {2'b01, 48'h0001_0000_0003},
           {2'b11, 48'hFFFF_FF00_0010}, {2'b00, 48'h0000_FFFF_0100}};
    for (int i = 0; i < 4; i++) begin
      wr(cad_pkg::OFS_DIV_HI, {16'h0, tc[i][47:32]});
      wr(cad_pkg::OFS_OPA, {16'h0, tc[i][31:16]});
      wr(cad_pkg::OFS_OPB, {16'h0, tc[i][15:0]});
      wr(cad_pkg::OFS_CMD, {25'h0, tc[i][48], tc[i][49], 5'h09});
      n = 0;
      repeat (40) begin
        @(posedge CLK);
        if (DIV_BUSY === 1'b1) n++;
      end
      `CHK("divide cycles", 19, n)
      dd = tc[i][48] ? tc[i][47:16] : {{16{tc[i][49] & tc[i][31]}}, tc[i][31:16]};
      dv = {{16{tc[i][49] & tc[i][15]}}, tc[i][15:0]};
      rdc(cad_pkg::OFS_QUOT, {16'h0, 16'(dd / dv)});
      rdc(cad_pkg::OFS_REM, {16'h0, 16'(dd % dv)});
    end
    $display("divide done");
  endtask

  // software access to status and control, nesting lock
  task automatic t_regs;
    wr(cad_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
    rdc(cad_pkg::OFS_CONTROL, 32'h0000_0004);
    `CHK("window enable", 1'b1, PROG_WINDOW_EN)
    wr(cad_pkg::OFS_CONTROL, 32'h0);
    rdc(cad_pkg::OFS_CONTROL, 32'h0);
    wr(cad_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rdc(cad_pkg::OFS_STATUS, 32'h0000_01EF);
    `CHK("level seven", 5'h17, {USER_IRQ_DISABLE, PRIORITY_LEVEL})
    wr(cad_pkg::OFS_MISC, 32'h1);
    wr(cad_pkg::OFS_STATUS, 32'h0);
    rdc(cad_pkg::OFS_STATUS, 32'h0000_00E0);
    wr(cad_pkg::OFS_MISC, 32'h0);
    wr(cad_pkg::OFS_STATUS, 32'h0000_0060);
    rdc(cad_pkg::OFS_STATUS, 32'h0000_0060);
    `CHK("level three", 5'h03, {USER_IRQ_DISABLE, PRIORITY_LEVEL})
    wr(cad_pkg::OFS_STATUS, 32'h0);
    $display("registers done");
  endtask

  // hardware loop flag and hardware priority raise, software clear
  task automatic t_hw;
    loop_req <= 1'b1;
    prio_req <= 1'b1;
    repeat (8) @(posedge CLK);
    rdc(cad_pkg::OFS_STATUS, 32'h0000_0010);
    rdc(cad_pkg::OFS_CONTROL, 32'h0000_0008);
    `CHK("level eight", 5'h18, {USER_IRQ_DISABLE, PRIORITY_LEVEL})
    loop_req <= 1'b0;
    prio_req <= 1'b0;
    repeat (8) @(posedge CLK);
    wr(cad_pkg::OFS_CONTROL, 32'h0);
    rdc(cad_pkg::OFS_CONTROL, 32'h0);
    rdc(cad_pkg::OFS_STATUS, 32'h0);
    $display("hardware status done");
  endtask

  // program address range and table page override
  task automatic t_paddr;
    wr(cad_pkg::OFS_PADDR, 32'h007F_FFFF);
    rdc(cad_pkg::OFS_PADDR, 32'h017F_FFFF);
    wr(cad_pkg::OFS_PADDR, 32'h0080_0000);
    rdc(cad_pkg::OFS_PADDR, 32'h0080_0000);
    `CHK("upper half refused", 1'b0, PROG_ADDR_OK)
    wr(cad_pkg::OFS_MISC, 32'h0000_8004);
    rdc(cad_pkg::OFS_PADDR, 32'h0180_0000);
    `CHK("table access allowed", 1'b1, PROG_ADDR_OK)
    wr(cad_pkg::OFS_MISC, 32'h0);
    $display("program address done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    NRST = 1'b0;
    HADDR = 32'h0;
    HWRITE = 1'b0;
    HTRANS = 2'b00;
    HWDATA = 32'h0;
    loop_req = 1'b0;
    prio_req = 1'b0;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    t_reset;
    t_alu;
    t_mul;
    t_div;
    t_regs;
    t_hw;
    t_paddr;
    stop_test;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
`default_nettype wire
